// ==== core/hs_supervisor_pkg.sv ====
// package: constants, register map and types for the hot swap supervisor
package hs_supervisor_pkg;

   // clock and long intervals
   localparam longint CLK_HZ        = 64'd250_000_000;  // mclk rate in hz
   localparam longint TEN_SEC_S     = 64'd10;           // retry window, cool time, good time in seconds
   localparam int     CNT_W         = 33;               // wide enough for ten seconds of mclk
   localparam logic [CNT_W-1:0] TEN_SEC_CNT = CNT_W'(TEN_SEC_S * CLK_HZ);

   // retry bookkeeping
   localparam logic [2:0] RETRY_LIMIT = 3'h7;           // events allowed before lockout

   // register map, byte addresses
   localparam int         ADDR_W     = 8;
   localparam logic [7:0] CTRL_ADDR  = 8'h00;
   localparam logic [7:0] STAT_ADDR  = 8'h04;
   localparam logic [7:0] MASK_ADDR  = 8'h08;
   localparam logic [7:0] STATE_ADDR = 8'h0c;

   // control register fields
   localparam int CTRL_VARIANT = 0;                     // 0: 2 mv sense limit, 1: 4 mv
   localparam int CTRL_ROUTE1  = 1;                     // fet health onto primary alert
   localparam int CTRL_ROUTE2  = 2;                     // fet health onto secondary alert
   localparam int CTRL_ENABLE  = 3;                     // hot swap function on
   localparam logic [3:0] CTRL_RESET = 4'ha;            // route1 and enable set

   // status and mask fields
   localparam int STAT_W       = 5;
   localparam int ST_OC_FAULT  = 0;
   localparam int ST_FET_BAD   = 1;
   localparam int ST_LIMIT     = 2;
   localparam int ST_SHUTDOWN_N_EVT  = 3;
   localparam int ST_RESTART   = 4;
   localparam logic [STAT_W-1:0] STAT_RESET = 5'h00;
   localparam logic [STAT_W-1:0] MASK_RESET = 5'h00;

   // hot swap states, gray along on -> latched -> halted -> cooling
   typedef enum logic [1:0] {
      HS_ON      = 2'b00,
      HS_LATCHED = 2'b01,
      HS_HALTED  = 2'b11,
      HS_COOLING = 2'b10
   } hs_state_e;

   // analog comparator decisions, one bit each
   typedef struct packed {
      logic drain_low;      // drain below 2 v
      logic gate_high;      // gate near upper rail
      logic gate_low;       // gate below about 1 v
      logic sense_over_lo;  // sense above 2 mv
      logic sense_over_hi;  // sense above 4 mv
      logic uv_rise;        // undervolt_rise_in above its threshold
      logic uv_fall;        // undervolt_fall_in above its threshold
   } cmp_s;

   localparam int   CMP_W     = $bits(cmp_s);
   localparam cmp_s CMP_RESET = '0;

endpackage : hs_supervisor_pkg

// ==== core/hs_supervisor.sv ====
// hot swap status outputs, shutdown/restart handling and retry supervision
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps

module hs_supervisor
   import hs_supervisor_pkg::*;
#(
   parameter logic [hs_supervisor_pkg::CNT_W-1:0] TEN_SEC_CYCLES = hs_supervisor_pkg::TEN_SEC_CNT
) (
   // clock and uvlo reset
   input  wire logic                                mclk,
   input  wire logic                                resetn,
   // comparator decisions
   input  wire hs_supervisor_pkg::cmp_s             cmp_in,
   input  wire logic                                ov_in,
   input  wire logic                                oc_fault_in,
   // system controller lines
   input  wire logic                                shutdown_n,
   input  wire logic                                restart_n,
   // register port
   input  wire logic [hs_supervisor_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]                         reg_wdata,
   input  wire logic                                reg_wr,
   input  wire logic                                reg_rd,
   output logic      [31:0]                         reg_rdata,
   // status outputs
   output logic                                     gate_on,
   output logic                                     power_good_n,
   output logic                                     supply_window_ok,
   output logic                                     lockout_n,
   output logic                                     primary_alert_out,
   output logic                                     secondary_alert_out,
   output logic                                     irq
);
   import hs_supervisor_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // comparator synchroniser

   cmp_s sync1_q;                        // first stage, read only by second
   cmp_s sync2_q;                        // usable comparator levels

   // one pair of flops per comparator bit
   genvar gi;
   generate
      for (gi = 0; gi < CMP_W; gi++) begin : g_sync
         always_ff @(posedge mclk) begin
            if (!resetn) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= cmp_in[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // state declarations

   hs_state_e          state_q, state_d;      // hot swap state
   logic               uv_fault_q, uv_fault_d; // undervolt held
   logic [2:0]         evt_cnt_q, evt_cnt_d;   // fault/shutdown events
   logic               limit_q, limit_d;       // seven-event alert
   logic [CNT_W-1:0]   win_cnt_q, win_cnt_d;   // event window timer
   logic [CNT_W-1:0]   pg_cnt_q, pg_cnt_d;     // continuous power good time
   logic [CNT_W-1:0]   cool_cnt_q, cool_cnt_d; // restart cool-down timer
   logic               shutdown_n_prev_q, rst_prev_q; // edge history
   logic [3:0]         ctrl_q, ctrl_d;         // control register
   logic [STAT_W-1:0]  stat_q, stat_d;         // sticky events
   logic [STAT_W-1:0]  mask_q, mask_d;         // interrupt mask
   logic [31:0]        rdata_d;
   logic               gate_d, pg_n_d, sup_ok_d, lock_n_d, alert1_d, alert2_d, irq_d;

   // combinational helpers
   logic               shutdown_n_fall, shutdown_n_rise, rst_fall, evt, fet_bad, pg_now;
   logic [STAT_W-1:0]  stat_set, stat_clr;

   ////////////////////////////////////////////////////////////////////////////
   // supervision next state

   always_comb begin
      shutdown_n_fall  = shutdown_n_prev_q & ~shutdown_n;
      shutdown_n_rise  = ~shutdown_n_prev_q & shutdown_n;
      rst_fall   = rst_prev_q & ~restart_n;                      // falling edge only
      state_d    = state_q;
      evt_cnt_d  = evt_cnt_q;
      limit_d    = limit_q;
      cool_cnt_d = cool_cnt_q;
      stat_set   = '0;

      // uv fault sets on low fall comparator, clears above rise threshold
      uv_fault_d = uv_fault_q;
      if (!sync2_q.uv_fall) begin
         uv_fault_d = 1'b1;
      end else if (sync2_q.uv_rise) begin
         uv_fault_d = 1'b0;
      end

      // an overcurrent only counts while the gate is really driven
      evt = (oc_fault_in & gate_on) | shutdown_n_fall;

      if (uv_fault_d) begin
         // undervolt wipes every latched condition
         state_d    = HS_ON;
         evt_cnt_d  = '0;
         limit_d    = 1'b0;
         cool_cnt_d = '0;
      end else if (rst_fall) begin
         // timed restart wins over latch-off and lockout
         state_d    = HS_COOLING;
         cool_cnt_d = '0;
         evt_cnt_d  = '0;
         limit_d    = 1'b0;
      end else begin
         if (evt && evt_cnt_q != RETRY_LIMIT) begin
            evt_cnt_d = evt_cnt_q + 3'h1;
         end
         unique case (state_q)
            HS_ON: begin
               if (oc_fault_in && gate_on) begin
                  state_d = HS_LATCHED;
                  stat_set[ST_OC_FAULT] = 1'b1;
               end else if (shutdown_n_rise && evt_cnt_q >= RETRY_LIMIT) begin
                  state_d = HS_HALTED;
               end
            end
            HS_LATCHED: begin
               if (!shutdown_n) begin
                  state_d = HS_ON;                               // low level releases
               end
            end
            HS_HALTED: begin
               state_d = HS_HALTED;                              // only uv or restart leave
            end
            HS_COOLING: begin
               if (cool_cnt_q >= TEN_SEC_CYCLES - CNT_W'(1)) begin
                  state_d = HS_ON;                               // fresh power-up
                  stat_set[ST_RESTART] = 1'b1;
               end else begin
                  cool_cnt_d = cool_cnt_q + CNT_W'(1);
               end
            end
         endcase
         if (evt_cnt_d == RETRY_LIMIT && !limit_q) begin
            limit_d = 1'b1;                                      // shutdown never clears it
            stat_set[ST_LIMIT] = 1'b1;
         end
         // event window: until the limit is set, count expires ten seconds after it started
         if (win_cnt_q >= TEN_SEC_CYCLES - CNT_W'(1) && !limit_q) begin
            evt_cnt_d = '0;
         end
         // ten seconds of continuous power good clears the count
         if (pg_cnt_q >= TEN_SEC_CYCLES - CNT_W'(1)) begin
            evt_cnt_d = '0;
         end
      end
      stat_set[ST_SHUTDOWN_N_EVT] = shutdown_n_fall;

      // window and power good timers, held clear in uv
      win_cnt_d = (evt_cnt_q == '0 || evt_cnt_d == '0 || uv_fault_d) ? '0 : win_cnt_q + CNT_W'(1);
      pg_now    = gate_on & sync2_q.drain_low & sync2_q.gate_high;
      pg_cnt_d  = (!pg_now || uv_fault_d || pg_cnt_q >= TEN_SEC_CYCLES - CNT_W'(1)) ? '0 :
                  pg_cnt_q + CNT_W'(1);

      // gate drive: enabled, on, not shut down, inside supply window
      gate_d = (state_d == HS_ON) && shutdown_n && ctrl_q[CTRL_ENABLE]
               && !uv_fault_d && !ov_in && !(oc_fault_in && gate_on);
      sup_ok_d = !uv_fault_d && !ov_in;
      // power good only with gate on and drain low, faults release it
      pg_n_d   = !(gate_d && sync2_q.drain_low && sync2_q.gate_high);
      lock_n_d = (state_d != HS_LATCHED);

      // shorted pass transistor while held off
      fet_bad  = !gate_on && sync2_q.gate_low &&
                 (ctrl_q[CTRL_VARIANT] ? sync2_q.sense_over_hi : sync2_q.sense_over_lo);
      stat_set[ST_FET_BAD] = fet_bad;
      alert1_d = fet_bad && ctrl_q[CTRL_ROUTE1];
      alert2_d = !(limit_d || (fet_bad && ctrl_q[CTRL_ROUTE2]));       // active low
   end

   ////////////////////////////////////////////////////////////////////////////
   // register port next values

   always_comb begin
      ctrl_d   = ctrl_q;
      mask_d   = mask_q;
      stat_clr = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            CTRL_ADDR: ctrl_d   = reg_wdata[3:0];
            STAT_ADDR: stat_clr = reg_wdata[STAT_W-1:0];
            MASK_ADDR: mask_d   = reg_wdata[STAT_W-1:0];
            default:   ctrl_d   = ctrl_q;                // unmapped writes ignored
         endcase
      end
      // a new event beats a write-one clear in the same cycle
      stat_d = (stat_q & ~stat_clr) | stat_set;
      irq_d  = |(stat_d & mask_d);
      // read data stands only in the cycle after the strobe
      rdata_d = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            CTRL_ADDR:  rdata_d = {28'h0000000, ctrl_q};
            STAT_ADDR:  rdata_d = {27'h0000000, stat_q};
            MASK_ADDR:  rdata_d = {27'h0000000, mask_q};
            STATE_ADDR: rdata_d = {25'h0000000, uv_fault_q, limit_q, evt_cnt_q, state_q};
            default:    rdata_d = '0;                    // unmapped reads zero
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   // all state loaded with reset values while uvlo holds reset: uv fault set, control at CTRL_RESET
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_q             <= HS_ON;
         uv_fault_q          <= 1'b1;
         evt_cnt_q           <= '0;
         limit_q             <= 1'b0;
         win_cnt_q           <= '0;
         pg_cnt_q            <= '0;
         cool_cnt_q          <= '0;
         shutdown_n_prev_q         <= 1'b1;
         rst_prev_q          <= 1'b1;
         ctrl_q              <= CTRL_RESET;             // primary route on
         stat_q              <= STAT_RESET;
         mask_q              <= MASK_RESET;
         reg_rdata           <= '0;
         gate_on             <= 1'b0;
         power_good_n        <= 1'b1;
         supply_window_ok    <= 1'b0;
         lockout_n           <= 1'b1;
         primary_alert_out   <= 1'b0;
         secondary_alert_out <= 1'b1;
         irq                 <= 1'b0;
      end else begin
         state_q             <= state_d;
         uv_fault_q          <= uv_fault_d;
         evt_cnt_q           <= evt_cnt_d;
         limit_q             <= limit_d;
         win_cnt_q           <= win_cnt_d;
         pg_cnt_q            <= pg_cnt_d;
         cool_cnt_q          <= cool_cnt_d;
         shutdown_n_prev_q         <= shutdown_n;
         rst_prev_q          <= restart_n;
         ctrl_q              <= ctrl_d;
         stat_q              <= stat_d;
         mask_q              <= mask_d;
         reg_rdata           <= rdata_d;
         gate_on             <= gate_d;
         power_good_n        <= pg_n_d;
         supply_window_ok    <= sup_ok_d;
         lockout_n           <= lock_n_d;
         primary_alert_out   <= alert1_d;
         secondary_alert_out <= alert2_d;
         irq                 <= irq_d;
      end
   end

endmodule : hs_supervisor

// ==== bench/hs_supervisor_sva.sv ====
// checker: port-level properties of the hot swap supervisor
`timescale 1ns/10ps
module hs_supervisor_sva
   import hs_supervisor_pkg::*;
#(
   parameter logic [hs_supervisor_pkg::CNT_W-1:0] TEN_SEC_CYCLES = hs_supervisor_pkg::TEN_SEC_CNT
) (
   // clock and reset
   input wire logic                    mclk,
   input wire logic                    resetn,
   // inputs seen by the block
   input wire hs_supervisor_pkg::cmp_s cmp_in,
   input wire logic                    ov_in,
   input wire logic                    oc_fault_in,
   input wire logic                    shutdown_n,
   input wire logic                    restart_n,
   input wire logic                    reg_rd,
   // outputs under watch
   input wire logic [31:0]             reg_rdata,
   input wire logic                    gate_on,
   input wire logic                    power_good_n,
   input wire logic                    supply_window_ok,
   input wire logic                    lockout_n,
   input wire logic                    secondary_alert_out
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic [CNT_W-1:0] cool_q;      // cycles since restart fell
   logic             cool_act_q;  // a cooling period is being timed
   ////////////////////////////////////////////////////////////////
   // helper: time the cooling period; cleared on gate rise so a later shutdown does not count
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cool_q     <= '0;
         cool_act_q <= 1'b0;
      end else if ($fell(restart_n)) begin
         cool_q     <= '0;
         cool_act_q <= 1'b1;
      end else if ($rose(gate_on)) begin
         cool_act_q <= 1'b0;
      end else begin
         cool_q <= cool_q + 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////
   // synchroniser delay allows two to four cycles of drain history
   a_pg_drain: assert property (!power_good_n |->
      $past(cmp_in.drain_low, 2) || $past(cmp_in.drain_low, 3) || $past(cmp_in.drain_low, 4))
      else $error("power good without drain low");
   a_shutdown_n_gate: assert property (!shutdown_n |=> !gate_on && power_good_n)
      else $error("gate on during shutdown");
   a_oc_lockout: assert property (gate_on && oc_fault_in && shutdown_n |=> !lockout_n && !gate_on)
      else $error("no lockout after overcurrent");
   a_restart_off: assert property ($fell(restart_n) |=> !gate_on [*2])
      else $error("gate on after restart fall");
   a_cool_length: assert property ($rose(gate_on) && cool_act_q |-> cool_q >= TEN_SEC_CYCLES - 1'b1)
      else $error("cooling period too short");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data without read");
   a_ov_window: assert property (ov_in |=> !supply_window_ok) else $error("supply ok during overvoltage");
   a_alert_sticky: assert property (!secondary_alert_out && restart_n && $changed(shutdown_n) |=>
      !secondary_alert_out) else $error("shutdown cleared secondary alert");
   // main scenarios reached
   c_restart: cover property ($fell(restart_n));
   c_lockout: cover property (!lockout_n);
   c_limit: cover property ($fell(secondary_alert_out));
endmodule : hs_supervisor_sva

// ==== bench/sys_ctl_model.sv ====
// system controller model: drives the shutdown and restart lines
`timescale 1ns/10ps
module sys_ctl_model (
   // clock
   input  wire logic mclk,
   // commands from the bench, high = act
   input  wire logic shutdown_n_cmd,
   input  wire logic rst_cmd,
   // push-pull lines into the supervisor
   output logic      shutdown_n,
   output logic      restart_n
);
   // lines change just after the edge; idle high as with the pull-ups
   always_ff @(posedge mclk) begin
      shutdown_n <= !shutdown_n_cmd;
      restart_n  <= !rst_cmd;
   end
endmodule : sys_ctl_model

// ==== bench/hs_supervisor_tb.sv ====
// testbench: hot swap supervisor scenarios with controller model and checker
`timescale 1ns/10ps
module hs_supervisor_tb;
   import hs_supervisor_pkg::*;
   localparam logic [CNT_W-1:0] TEN_SEC_CYCLES = 33'h64; // ten seconds shortened to 100 cycles
   logic mclk = 1'b0, resetn = 1'b0, ov_in = 1'b0, oc_fault_in = 1'b0;
   logic shutdown_n_cmd = 1'b0, rst_cmd = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v;
   cmp_s cmp_in = CMP_RESET;
   logic shutdown_n, restart_n, gate_on, power_good_n, supply_window_ok, lockout_n;
   logic primary_alert_out, secondary_alert_out, irq;
   int miscompares = 0, checks = 0;
   always #2 mclk = ~mclk; // 250 mhz
   sys_ctl_model i_sys_ctl_model (.mclk(mclk), .shutdown_n_cmd(shutdown_n_cmd), .rst_cmd(rst_cmd),
      .shutdown_n(shutdown_n), .restart_n(restart_n));
   hs_supervisor #(.TEN_SEC_CYCLES(TEN_SEC_CYCLES)) i_hs_supervisor (.mclk(mclk), .resetn(resetn),
      .cmp_in(cmp_in), .ov_in(ov_in), .oc_fault_in(oc_fault_in), .shutdown_n(shutdown_n),
      .restart_n(restart_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gate_on(gate_on), .power_good_n(power_good_n),
      .supply_window_ok(supply_window_ok), .lockout_n(lockout_n), .primary_alert_out(primary_alert_out),
      .secondary_alert_out(secondary_alert_out), .irq(irq));
   ////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (miscompares == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // wait n edges, then settle past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask : rd
   // bounded wait for the gate to reach a level
   task automatic wait_gate(input logic v);
      for (int i = 0; i < 300; i++) begin
         if (gate_on === v) return;
         cyc(1);
      end
      miscompares++;
      report_and_stop();
   endtask : wait_gate
   // both undervoltage comparators low then high again
   task automatic uv_toggle();
      cmp_in.uv_rise <= 1'b0;
      cmp_in.uv_fall <= 1'b0;
      cyc(4);
      cmp_in.uv_rise <= 1'b1;
      cmp_in.uv_fall <= 1'b1;
      cyc(4);
   endtask : uv_toggle
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      cyc(1);
      chk(power_good_n, 1'b1);
      chk(gate_on, 1'b0);
      rd(CTRL_ADDR);
      chk(rd_v, 32'ha);
      rd(STAT_ADDR);
      chk(rd_v, 32'h0);
      rd(MASK_ADDR);
      chk(rd_v, 32'h0);
      rd(8'h10);
      chk(rd_v, 32'h0);
   endtask : t_reset
   task automatic t_power_up();
      cmp_in <= cmp_s'(7'h63); // drain low, gate high, uv both high
      wait_gate(1'b1);
      cyc(5);
      chk(power_good_n, 1'b0);
      chk(supply_window_ok, 1'b1);
      cmp_in.drain_low <= 1'b0;
      cyc(1);
      chk(power_good_n, 1'b0);
      cyc(4);
      chk(power_good_n, 1'b1);
      cmp_in.drain_low <= 1'b1;
      ov_in <= 1'b1;
      cyc(2);
      chk(supply_window_ok, 1'b0);
      ov_in <= 1'b0;
      wait_gate(1'b1);
      cyc(5);
   endtask : t_power_up
   task automatic t_oc();
      wr(MASK_ADDR, 32'h1);
      oc_fault_in <= 1'b1;
      cyc(1);
      oc_fault_in <= 1'b0;
      chk(lockout_n, 1'b0);
      chk(irq, 1'b1);
      rd(STAT_ADDR);
      chk(rd_v[ST_OC_FAULT], 1'b1);
      wr(STAT_ADDR, 32'h1);
      cyc(1);
      chk(irq, 1'b0);
      cyc(5);
      chk(gate_on, 1'b0);
      shutdown_n_cmd <= 1'b1;
      cyc(3);
      shutdown_n_cmd <= 1'b0;
      wait_gate(1'b1);
      chk(lockout_n, 1'b1);
   endtask : t_oc
   task automatic t_fet();
      shutdown_n_cmd <= 1'b1;
      cmp_in <= cmp_s'(7'h5b); // gate low, sense above 2 mv only
      cyc(8);
      chk(primary_alert_out, 1'b1);
      chk(secondary_alert_out, 1'b1);
      wr(CTRL_ADDR, 32'hc);
      cyc(2);
      chk(primary_alert_out, 1'b0);
      chk(secondary_alert_out, 1'b0);
      wr(CTRL_ADDR, 32'hd);
      wr(STAT_ADDR, 32'h2);
      cyc(4);
      chk(secondary_alert_out, 1'b1);
      wr(CTRL_ADDR, 32'ha);
      shutdown_n_cmd <= 1'b0;
      // toggle first so cmp_in is never assigned twice in one step
      uv_toggle();
      cmp_in <= cmp_s'(7'h63);
      wait_gate(1'b1);
   endtask : t_fet
   task automatic t_seven();
      for (int i = 1; i <= 7; i++) begin
         shutdown_n_cmd <= 1'b1;
         cyc(3);
         chk(gate_on, 1'b0);
         chk(secondary_alert_out, i < 7);
         shutdown_n_cmd <= 1'b0;
         if (i < 7) wait_gate(1'b1);
      end
      cyc(10);
      chk(gate_on, 1'b0);
      shutdown_n_cmd <= 1'b1;
      cyc(3);
      shutdown_n_cmd <= 1'b0;
      cyc(10);
      chk(secondary_alert_out, 1'b0);
      // halted with limit set and a full event count
      rd(STATE_ADDR);
      chk(rd_v, {25'h0000000, 1'b0, 1'b1, RETRY_LIMIT, HS_HALTED});
      uv_toggle();
      wait_gate(1'b1);
      chk(secondary_alert_out, 1'b1);
   endtask : t_seven
   task automatic t_restart();
      rst_cmd <= 1'b1;
      cyc(3);
      chk(gate_on, 1'b0);
      cyc(80);
      chk(gate_on, 1'b0);
      wait_gate(1'b1);
      cyc(150);
      chk(gate_on, 1'b1);
      rd(STAT_ADDR);
      chk(rd_v[ST_RESTART], 1'b1);
      rst_cmd <= 1'b0;
      cyc(5);
      chk(gate_on, 1'b1);
   endtask : t_restart
   ////////////////////////////////////////////////////////////////
   // main sequence, reset held ten cycles
   initial begin
      cyc(10);
      resetn <= 1'b1;
      t_reset();
      t_power_up();
      t_oc();
      t_fet();
      t_seven();
      t_restart();
      report_and_stop();
   end
endmodule : hs_supervisor_tb
bind hs_supervisor hs_supervisor_sva #(.TEN_SEC_CYCLES(TEN_SEC_CYCLES)) i_hs_supervisor_sva (.mclk(mclk),
   .resetn(resetn), .cmp_in(cmp_in), .ov_in(ov_in), .oc_fault_in(oc_fault_in), .shutdown_n(shutdown_n),
   .restart_n(restart_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gate_on(gate_on),
   .power_good_n(power_good_n), .supply_window_ok(supply_window_ok), .lockout_n(lockout_n),
   .secondary_alert_out(secondary_alert_out));
